// ==== verilog/ccg_pkg.sv ====
package ccg_pkg;
	// Datapath geometry
	localparam int NCH = 4;
	localparam int CH_A = 0;
	localparam int CH_B = 1;
	localparam int CH_C = 2;
	localparam int CH_N = 3;
	localparam int CODE_W = 24;
	localparam int WORD_W = 32;
	localparam int DSP_W = 28;
	localparam int PAD_W = 4;
	localparam int OFFS_W = 8;
	localparam int OFFSET_SHIFT = 11;
	localparam int FRAC_SHIFT = 23;
	localparam logic [CODE_W-1:0] CODE_MAX = 24'h7FFFFF;
	localparam logic [CODE_W-1:0] CODE_MIN = 24'h800000;

	// Clocking and rates
	localparam int SYS_CLK_HZ = 25000000;
	localparam int XTAL_HZ = 4096000;
	localparam int MOD_SAMPLE_HZ = 1024000;
	localparam int SYNC_DIV = XTAL_HZ / MOD_SAMPLE_HZ;
	localparam int DIV_W = 2;
	localparam int OUT_RATE_HZ = 8000;
	localparam int DECIM = MOD_SAMPLE_HZ / OUT_RATE_HZ;
	localparam int DECIM_W = 7;
	localparam int CIC_GAIN_SHIFT = 2;

	// Temperature start-up wait: 1024 ms
	localparam int TEMP_WAIT_MS = 1024;
	localparam int TEMP_WAIT_CYC = (SYS_CLK_HZ / 1000) * TEMP_WAIT_MS;
	localparam int WAIT_W = 32;

	// Register indices
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] ADDR_GAIN_BASE = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_SHUNT_TEMP_COEFFICIENT = 4'h4;
	localparam logic [ADDR_W-1:0] ADDR_REF_BASE = 4'h5;
	localparam logic [ADDR_W-1:0] ADDR_MEAS_BASE = 4'h9;
	localparam logic [ADDR_W-1:0] ADDR_CHSEL = 4'hD;

	// Reset values
	localparam logic [CODE_W-1:0] GAIN_RESET = 24'h000000;
	localparam logic [CODE_W-1:0] SHUNT_TEMP_COEFFICIENT_RESET = 24'h000000;
	localparam logic [CODE_W-1:0] TEMP_RESET = 24'h000000;
	localparam logic [NCH-1:0] CHSEL_RESET = 4'hF;

	typedef logic signed [CODE_W-1:0] ccg_code_t;
	typedef enum logic [1:0] {TS_IDLE, TS_WAIT, TS_ACTIVE} ccg_tstate_t;

	// Clamp a wide signed value to the 24-bit code range
	function automatic ccg_code_t ccg_sat24(input logic signed [49:0] v);
		if (v[49:23] == {27{1'b0}} || v[49:23] == {27{1'b1}}) begin
			return v[23:0];
		end
		return v[49] ? CODE_MIN : CODE_MAX;
	endfunction
endpackage

// ==== verilog/ccg_dec_if.sv ====
`timescale 1ns/100ps
interface ccg_dec_if;
	logic signed [23:0] code;
	logic tog;
	modport src (output code, output tog);
	modport dst (input code, input tog);
endinterface

// ==== verilog/ccg_scale.sv ====
`timescale 1ns/100ps
module ccg_scale (
	// Operands
	input wire ccg_pkg::ccg_code_t x,
	input wire logic signed [25:0] k,
	// Result
	output logic signed [23:0] y
);
	import ccg_pkg::*;
	logic signed [49:0] prod;
	logic signed [49:0] sum;
	// y = x * (1 + k / 2^23), clamped instead of wrapping
	always_comb begin
		prod = 50'(x) * 50'(k);
		sum = $signed({{26{x[23]}}, x}) + (prod >>> FRAC_SHIFT);
		y = ccg_sat24(sum);
	end
endmodule // ccg_scale

// ==== verilog/ccg_decim.sv ====
`timescale 1ns/100ps
module ccg_decim (
	// Link clock domain
	input wire logic link_clk,
	input wire logic link_rst_n,
	input wire logic samp_en,
	// Modulator bit from the pin
	input wire logic bit_pin,
	// Decimated code
	ccg_dec_if.src dec
);
	import ccg_pkg::*;
	logic bit_meta;
	logic bit_sync;
	logic signed [23:0] int1_reg, int2_reg, int3_reg;
	logic signed [23:0] int3_prev, c1_prev, c2_prev;
	logic signed [23:0] c1, c2, c3, xin;
	logic [DECIM_W-1:0] dcnt_reg;
	logic signed [23:0] code_reg;
	logic tog_reg;

	always_ff @(posedge link_clk) begin
		bit_meta <= bit_pin;
		bit_sync <= bit_meta;
	end

	// Bits map to +1 / -1; integrator widths wrap safely since comb output stays below 2^22
	always_comb begin
		xin = bit_sync ? 24'sh000001 : 24'shFFFFFF;
		c1 = int3_reg - int3_prev;
		c2 = c1 - c1_prev;
		c3 = c2 - c2_prev;
	end

	// Third-order CIC, decimate by 128, suppresses shaped noise above the band
	always_ff @(posedge link_clk) begin
		if (!link_rst_n) begin
			int1_reg <= '0;
			int2_reg <= '0;
			int3_reg <= '0;
			int3_prev <= '0;
			c1_prev <= '0;
			c2_prev <= '0;
			dcnt_reg <= '0;
			code_reg <= '0;
			tog_reg <= 1'b0;
		end else if (samp_en) begin
			int1_reg <= int1_reg + xin;
			int2_reg <= int2_reg + int1_reg;
			int3_reg <= int3_reg + int2_reg;
			if (dcnt_reg == DECIM_W'(DECIM - 1)) begin
				dcnt_reg <= '0;
				int3_prev <= int3_reg;
				c1_prev <= c1;
				c2_prev <= c2;
				code_reg <= ccg_sat24(50'(c3) <<< CIC_GAIN_SHIFT);
				tog_reg <= ~tog_reg;
			end else begin
				dcnt_reg <= dcnt_reg + 1'b1;
			end
		end
	end

	assign dec.code = code_reg;
	assign dec.tog = tog_reg;
endmodule // ccg_decim

// ==== verilog/ccg_top.sv ====
`timescale 1ns/100ps
// Function
// - Sync clock to the modulators is the crystal clock divided by four.
// - Remote parts shift bits out on the sync clock the host drives.
// - Filter every received bit stream into signed 24-bit codes per channel.
// - Codes span the full signed range 0x800000 to 0x7FFFFF.
// - Nominal full-scale input gives roughly 5,320,000; limits allow spread.
// - Current results are two's complement 24-bit words at 8 kSPS.
// - Low-pass decimation removes the shaped high-frequency quantization noise.
// - Scale each current by one plus gain register over 2^23.
// - Gain 0x400000 raises by half, 0xC00000 lowers by half.
// - Scaled current feeds every later calculation and the stored samples.
// - Ports move 32-bit words, internal words are 28 bits.
// - 24-bit registers go out sign-extended to 28 bits plus four zeros.
// - One shared signed 24-bit shunt temperature coefficient for all channels.
// - Scale further by one minus coefficient times temperature difference over 2^46.
// - One signed 24-bit reference temperature register per channel.
// - One signed 24-bit measured temperature register per channel.
// - Measurement starts on select low; first results land 1.024 s later.
// - Compensation turns on after first results and updates at 8 kHz.
// - Four select bits drive select pins; high picks voltage, default high.
// - Sensor offset is shifted left eleven bits and added to temperature.
module ccg_top #(
	parameter int unsigned TEMP_WAIT_CYCLES = ccg_pkg::TEMP_WAIT_CYC
) (
	// System clock, reset, enable
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic sys_en,
	// Crystal clock, clocks the link side
	input wire logic crystal_input,
	// Modulator link
	output logic sync_clk_out,
	input wire logic [ccg_pkg::NCH-1:0] current_bitstream,
	// Channel select pins
	output logic phase_a_channel_select,
	output logic phase_b_channel_select,
	output logic phase_c_channel_select,
	output logic neutral_channel_select,
	// Temperature codes from the sensor path, same clock
	input wire logic [ccg_pkg::NCH-1:0] temp_code_valid,
	input wire logic [ccg_pkg::NCH-1:0][ccg_pkg::CODE_W-1:0] sensor_temp_code,
	input wire logic [ccg_pkg::NCH-1:0][ccg_pkg::OFFS_W-1:0] sensor_offset,
	// Register word port
	input wire logic [ccg_pkg::ADDR_W-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [ccg_pkg::WORD_W-1:0] reg_wdata,
	output logic [ccg_pkg::WORD_W-1:0] reg_rdata,
	// Compensated current samples
	output ccg_pkg::ccg_code_t phase_a_current_sample,
	output ccg_pkg::ccg_code_t phase_b_current_sample,
	output ccg_pkg::ccg_code_t phase_c_current_sample,
	output ccg_pkg::ccg_code_t neutral_current_sample,
	output logic [ccg_pkg::NCH-1:0] sample_valid
);
	import ccg_pkg::*;

	// Serial word layout: sign-extended to 28 bits, four zero pad bits
	function automatic logic [WORD_W-1:0] pack_word(input logic [CODE_W-1:0] v);
		return {{(DSP_W - CODE_W){v[CODE_W-1]}}, v, {PAD_W{1'b0}}};
	endfunction

	// True when an address hits the given channel within a four-register bank
	function automatic logic bank_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base, input int ch);
		return a == (base + ADDR_W'(ch));
	endfunction

	// ---------------- Link clock domain ----------------
	logic link_rst_meta;
	logic link_rst_n;
	logic [DIV_W-1:0] div_reg;
	logic sync_reg;
	logic samp_en;

	// Reset brought onto the crystal clock through two flops
	always_ff @(posedge crystal_input) begin
		link_rst_meta <= reset_n;
		link_rst_n <= link_rst_meta;
	end

	always_ff @(posedge crystal_input) begin
		if (!link_rst_n) begin
			div_reg <= '0;
			sync_reg <= 1'b0;
		end else begin
			div_reg <= div_reg + 1'b1;
			sync_reg <= (div_reg >= DIV_W'(SYNC_DIV / 2 - 1)) && (div_reg != DIV_W'(SYNC_DIV - 1));
		end
	end

	// Take a bit once per sync period, well after the remote edge has settled
	assign samp_en = (div_reg == DIV_W'(SYNC_DIV - 1));
	assign sync_clk_out = sync_reg;

	ccg_dec_if dec_if [NCH] ();
	ccg_code_t dec_code [NCH];
	logic [NCH-1:0] dec_tog;

	// Neutral input reads as a constant high when unmonitored, giving a clamped code
	generate
		for (genvar g = 0; g < NCH; g++) begin : g_dec
			ccg_decim u_decim (
				.link_clk(crystal_input),
				.link_rst_n(link_rst_n),
				.samp_en(samp_en),
				.bit_pin(current_bitstream[g]),
				.dec(dec_if[g].src)
			);
			assign dec_code[g] = dec_if[g].code;
			assign dec_tog[g] = dec_if[g].tog;
		end
	endgenerate

	// ---------------- System clock domain ----------------
	logic [NCH-1:0] tog_meta;
	logic [NCH-1:0] tog_sync;
	logic [NCH-1:0] tog_seen;
	logic [NCH-1:0] new_sample;

	// Toggle handshake; the code word is stable for 512 crystal cycles after each toggle
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			tog_meta <= '0;
			tog_sync <= '0;
			tog_seen <= '0;
		end else if (sys_en) begin
			tog_meta <= dec_tog;
			tog_sync <= tog_meta;
			tog_seen <= tog_sync;
		end
	end
	assign new_sample = tog_sync ^ tog_seen;

	// Register file
	ccg_code_t gain_reg [NCH];
	ccg_code_t ref_reg [NCH];
	ccg_code_t meas_reg [NCH];
	ccg_code_t shunt_temp_coefficient_reg;
	logic [NCH-1:0] chsel_reg;
	logic [WORD_W-1:0] rdata_reg;
	logic [CODE_W-1:0] wr_value;

	assign wr_value = reg_wdata[DSP_W-1:PAD_W];

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			for (int ch = 0; ch < NCH; ch++) begin
				gain_reg[ch] <= GAIN_RESET;
				ref_reg[ch] <= TEMP_RESET;
			end
		end else if (sys_en && reg_wr) begin
			for (int ch = 0; ch < NCH; ch++) begin
				if (bank_hit(reg_addr, ADDR_GAIN_BASE, ch)) begin
					gain_reg[ch] <= wr_value;
				end
				if (bank_hit(reg_addr, ADDR_REF_BASE, ch)) begin
					ref_reg[ch] <= wr_value;
				end
			end
		end
	end

	// Any 24-bit value is accepted; the positive limit is software's to keep
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			shunt_temp_coefficient_reg <= SHUNT_TEMP_COEFFICIENT_RESET;
		end else if (sys_en && reg_wr && reg_addr == ADDR_SHUNT_TEMP_COEFFICIENT) begin
			shunt_temp_coefficient_reg <= wr_value;
		end
	end

	// Selects power up high so every remote part starts on its voltage input
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			chsel_reg <= CHSEL_RESET;
		end else if (sys_en && reg_wr && reg_addr == ADDR_CHSEL) begin
			chsel_reg <= reg_wdata[NCH-1:0];
		end
	end

	// Read data registered, one cycle after the address; unmapped reads zero
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			rdata_reg <= '0;
		end else if (sys_en) begin
			rdata_reg <= '0;
			for (int ch = 0; ch < NCH; ch++) begin
				if (bank_hit(reg_addr, ADDR_GAIN_BASE, ch)) begin
					rdata_reg <= pack_word(gain_reg[ch]);
				end
				if (bank_hit(reg_addr, ADDR_REF_BASE, ch)) begin
					rdata_reg <= pack_word(ref_reg[ch]);
				end
				if (bank_hit(reg_addr, ADDR_MEAS_BASE, ch)) begin
					rdata_reg <= pack_word(meas_reg[ch]);
				end
			end
			if (reg_addr == ADDR_SHUNT_TEMP_COEFFICIENT) begin
				rdata_reg <= pack_word(shunt_temp_coefficient_reg);
			end
			if (reg_addr == ADDR_CHSEL) begin
				rdata_reg <= {{(WORD_W - NCH){1'b0}}, chsel_reg};
			end
		end
	end
	assign reg_rdata = rdata_reg;

	assign phase_a_channel_select = chsel_reg[CH_A];
	assign phase_b_channel_select = chsel_reg[CH_B];
	assign phase_c_channel_select = chsel_reg[CH_C];
	assign neutral_channel_select = chsel_reg[CH_N];

	// Temperature start-up sequencing per channel
	ccg_tstate_t tstate_reg [NCH];
	logic [WAIT_W-1:0] wait_cnt [NCH];
	ccg_code_t temp_in [NCH];

	always_comb begin
		for (int ch = 0; ch < NCH; ch++) begin
			temp_in[ch] = ccg_sat24($signed({{26{sensor_temp_code[ch][CODE_W-1]}}, sensor_temp_code[ch]})
				+ $signed({{31{sensor_offset[ch][OFFS_W-1]}}, sensor_offset[ch], {OFFSET_SHIFT{1'b0}}}));
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			for (int ch = 0; ch < NCH; ch++) begin
				tstate_reg[ch] <= TS_IDLE;
				wait_cnt[ch] <= '0;
				meas_reg[ch] <= TEMP_RESET;
			end
		end else if (sys_en) begin
			for (int ch = 0; ch < NCH; ch++) begin
				case (tstate_reg[ch])
					TS_IDLE: begin
						wait_cnt[ch] <= '0;
						if (!chsel_reg[ch]) begin
							tstate_reg[ch] <= TS_WAIT;
						end
					end
					TS_WAIT: begin
						if (chsel_reg[ch]) begin
							tstate_reg[ch] <= TS_IDLE;
						end else if (wait_cnt[ch] < WAIT_W'(TEMP_WAIT_CYCLES - 1)) begin
							wait_cnt[ch] <= wait_cnt[ch] + 1'b1;
						end else if (temp_code_valid[ch]) begin
							meas_reg[ch] <= temp_in[ch];
							tstate_reg[ch] <= TS_ACTIVE;
						end
					end
					TS_ACTIVE: begin
						if (chsel_reg[ch]) begin
							tstate_reg[ch] <= TS_IDLE;
						end else if (temp_code_valid[ch]) begin
							meas_reg[ch] <= temp_in[ch];
						end
					end
					default: begin
						tstate_reg[ch] <= TS_IDLE;
					end
				endcase
			end
		end
	end

	// Two-stage scaling pipeline per channel
	ccg_code_t raw_reg [NCH];
	ccg_code_t gained_reg [NCH];
	ccg_code_t out_reg [NCH];
	ccg_code_t gain_y [NCH];
	ccg_code_t temp_y [NCH];
	logic signed [25:0] gain_k [NCH];
	logic signed [25:0] temp_k [NCH];
	logic [NCH-1:0] raw_vld;
	logic [NCH-1:0] gain_vld;
	logic [NCH-1:0] out_vld;

	generate
		for (genvar g = 0; g < NCH; g++) begin : g_path
			logic signed [24:0] tdiff;
			logic signed [48:0] tprod;
			assign tdiff = {meas_reg[g][CODE_W-1], meas_reg[g]} - {ref_reg[g][CODE_W-1], ref_reg[g]};
			assign tprod = 49'(shunt_temp_coefficient_reg) * 49'(tdiff);
			// Negated so the shared scaler computes 1 - coef * dT / 2^46
			assign temp_k[g] = (tstate_reg[g] == TS_ACTIVE) ? -tprod[48:23] : 26'sh0;
			assign gain_k[g] = {{2{gain_reg[g][CODE_W-1]}}, gain_reg[g]};
			ccg_scale u_gain (
				.x(raw_reg[g]),
				.k(gain_k[g]),
				.y(gain_y[g])
			);
			ccg_scale u_temp (
				.x(gained_reg[g]),
				.k(temp_k[g]),
				.y(temp_y[g])
			);
		end
	endgenerate

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			for (int ch = 0; ch < NCH; ch++) begin
				raw_reg[ch] <= '0;
				gained_reg[ch] <= '0;
				out_reg[ch] <= '0;
			end
		end else if (sys_en) begin
			for (int ch = 0; ch < NCH; ch++) begin
				if (new_sample[ch]) begin
					raw_reg[ch] <= dec_code[ch];
				end
				if (raw_vld[ch]) begin
					gained_reg[ch] <= gain_y[ch];
				end
				if (gain_vld[ch]) begin
					out_reg[ch] <= temp_y[ch];
				end
			end
		end
	end

	// Valid bits walk beside the data, one stage per register
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			raw_vld <= '0;
			gain_vld <= '0;
			out_vld <= '0;
		end else if (sys_en) begin
			raw_vld <= new_sample;
			gain_vld <= raw_vld;
			out_vld <= gain_vld;
		end
	end

	// Only the fully scaled value leaves the block, so every consumer sees it
	assign phase_a_current_sample = out_reg[CH_A];
	assign phase_b_current_sample = out_reg[CH_B];
	assign phase_c_current_sample = out_reg[CH_C];
	assign neutral_current_sample = out_reg[CH_N];
	assign sample_valid = out_vld & {NCH{sys_en}};
endmodule // ccg_top

// ==== test/ccg_top_chk.sv ====
`timescale 1ns/100ps
module ccg_top_chk #(
	parameter int unsigned TEMP_WAIT_CYCLES = 50
) (
	// Clocks and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic sys_en,
	input wire logic crystal_input,
	// Link and selects
	input wire logic sync_clk_out,
	input wire logic phase_a_channel_select,
	input wire logic phase_b_channel_select,
	input wire logic phase_c_channel_select,
	input wire logic neutral_channel_select,
	// Register port
	input wire logic [ccg_pkg::ADDR_W-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [ccg_pkg::WORD_W-1:0] reg_wdata,
	input wire logic [ccg_pkg::WORD_W-1:0] reg_rdata,
	// Samples
	input wire ccg_pkg::ccg_code_t phase_a_current_sample,
	input wire logic [ccg_pkg::NCH-1:0] sample_valid
);
	import ccg_pkg::*;
	logic [3:0] sel;
	logic [7:0] gap_reg;
	logic seen_reg;
	assign sel = {neutral_channel_select, phase_c_channel_select, phase_b_channel_select, phase_a_channel_select};
	// Cycles since the last phase A sample, saturating
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			gap_reg <= 8'h00;
			seen_reg <= 1'b0;
		end else if (sample_valid[0]) begin
			gap_reg <= 8'h00;
			seen_reg <= 1'b1;
		end else if (gap_reg != 8'hFF) begin
			gap_reg <= gap_reg + 8'h01;
		end
	end
	sequence s_sync_pair;
		sync_clk_out ##1 !sync_clk_out;
	endsequence
	sequence s_sel_read;
		sys_en && !reg_wr && reg_addr == ADDR_CHSEL;
	endsequence
	property p_sync_div;
		@(posedge crystal_input) disable iff (!reset_n)
		$rose(sync_clk_out) |=> s_sync_pair ##1 !sync_clk_out ##1 sync_clk_out;
	endproperty
	a_sync_div: assert property (p_sync_div) else $error("sync clock is not crystal over four");
	property p_sel_read;
		@(posedge sys_clk) disable iff (!reset_n)
		s_sel_read |=> reg_rdata == {28'h0000000, sel};
	endproperty
	a_sel_read: assert property (p_sel_read) else $error("select readback wrong");
	property p_sel_write;
		@(posedge sys_clk) disable iff (!reset_n)
		sys_en && reg_wr && reg_addr == ADDR_CHSEL |=> sel == $past(reg_wdata[3:0]);
	endproperty
	a_sel_write: assert property (p_sel_write) else $error("select pins did not follow write");
	property p_word_pad;
		@(posedge sys_clk) disable iff (!reset_n)
		sys_en && reg_addr <= 4'hC |=> reg_rdata[3:0] == 4'h0 && reg_rdata[31:28] == {4{reg_rdata[27]}};
	endproperty
	a_word_pad: assert property (p_word_pad) else $error("read word not sign extended and padded");
	property p_unmapped;
		@(posedge sys_clk) disable iff (!reset_n)
		sys_en && reg_addr >= 4'hE |=> reg_rdata == 32'h00000000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_valid_pulse;
		@(posedge sys_clk) disable iff (!reset_n)
		sample_valid[0] |=> !sample_valid[0];
	endproperty
	a_valid_pulse: assert property (p_valid_pulse) else $error("sample valid longer than one cycle");
	property p_sample_hold;
		@(posedge sys_clk) disable iff (!reset_n)
		!sample_valid[0] |-> $stable(phase_a_current_sample);
	endproperty
	a_sample_hold: assert property (p_sample_hold) else $error("sample changed without valid");
	property p_valid_gap;
		@(posedge sys_clk) disable iff (!reset_n)
		sample_valid[0] && seen_reg |-> gap_reg >= 8'h95;
	endproperty
	a_valid_gap: assert property (p_valid_gap) else $error("samples closer than the output rate");
	property p_reset_state;
		@(posedge sys_clk)
		!reset_n |=> sample_valid == 4'h0 && sel == 4'hF && reg_rdata == 32'h00000000;
	endproperty
	a_reset_state: assert property (p_reset_state) else $error("reset state wrong");
endmodule // ccg_top_chk

// ==== test/ccg_mod_model.sv ====
`timescale 1ns/100ps
module ccg_mod_model (
	// Sync clock from the host
	input wire logic sync_clk_out,
	// Input level seen by phases A to C
	input wire logic level,
	// Bit streams
	output logic [3:0] current_bitstream
);
	initial current_bitstream = 4'hF;
	// Shift on the falling edge so the host samples a settled bit
	always @(negedge sync_clk_out) begin
		current_bitstream <= {1'b1, {3{level}}};
	end
endmodule // ccg_mod_model

// ==== test/tb.sv ====
`timescale 1ns/100ps
module tb;
	import ccg_pkg::*;
	typedef struct {logic [3:0] a; logic [31:0] d; logic [31:0] e;} ccg_row_t;
	logic sys_clk, reset_n, sys_en, crystal_input, level, sync_clk_out, reg_wr;
	logic sel_a, sel_b, sel_c, sel_n;
	logic [3:0] bits, tvalid, reg_addr, sample_valid;
	logic [3:0][23:0] tcode;
	logic [3:0][7:0] toffs;
	logic [31:0] reg_wdata, reg_rdata, d;
	ccg_code_t samp_a, samp_b, samp_c, samp_n;
	int err_count = 0;
	int n_compared = 0;
	int cyc = 0;
	// Register rows: index, write word, readback
	ccg_row_t regs[10] = '{'{4'h0, 32'h04000000, 32'h04000000}, '{4'h1, 32'hFC000000, 32'hFC000000},
		'{4'h2, 32'h07FFFFF0, 32'h07FFFFF0}, '{4'h3, 32'h08000000, 32'hF8000000},
		'{4'h4, 32'h004AE9B0, 32'h004AE9B0}, '{4'h5, 32'h00123450, 32'h00123450},
		'{4'h8, 32'h0FFFFFF0, 32'hFFFFFFF0}, '{4'h9, 32'h01234560, 32'h00000000},
		'{4'hE, 32'hFFFFFFFF, 32'h00000000}, '{4'hD, 32'h0000000A, 32'h0000000A}};
	// Datapath rows: input level, gain word, expected sample
	ccg_row_t dp[6] = '{'{4'h1, 32'h00000000, 32'h007FFFFF}, '{4'h1, 32'hFC000000, 32'h003FFFFF},
		'{4'h1, 32'h04000000, 32'h007FFFFF}, '{4'h0, 32'h04000000, 32'h00800000},
		'{4'h0, 32'hFC000000, 32'h00C00000}, '{4'h0, 32'h00000000, 32'h00800000}};

	ccg_top #(.TEMP_WAIT_CYCLES(50)) ccg_top_inst (.sys_clk(sys_clk), .reset_n(reset_n), .sys_en(sys_en),
		.crystal_input(crystal_input), .sync_clk_out(sync_clk_out), .current_bitstream(bits),
		.phase_a_channel_select(sel_a), .phase_b_channel_select(sel_b), .phase_c_channel_select(sel_c),
		.neutral_channel_select(sel_n), .temp_code_valid(tvalid), .sensor_temp_code(tcode),
		.sensor_offset(toffs), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .phase_a_current_sample(samp_a), .phase_b_current_sample(samp_b),
		.phase_c_current_sample(samp_c), .neutral_current_sample(samp_n), .sample_valid(sample_valid));
	ccg_mod_model ccg_mod_model_inst (.sync_clk_out(sync_clk_out), .level(level), .current_bitstream(bits));

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	// Link clock, phase unrelated to the system clock
	initial begin
		crystal_input = 1'b0;
		#3;
		forever #6 crystal_input = ~crystal_input;
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 30000) begin
			err_count++;
			$display("timeout");
			results();
		end
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic rst;
		reset_n = 1'b0;
		repeat (5) @(posedge sys_clk);
		#1;
		reset_n = 1'b1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] w);
		@(posedge sys_clk);
		#1;
		reg_addr = a;
		reg_wdata = w;
		reg_wr = 1'b1;
		@(posedge sys_clk);
		#1;
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] r);
		@(posedge sys_clk);
		#1;
		reg_addr = a;
		@(posedge sys_clk);
		#1;
		r = reg_rdata;
	endtask
	task automatic wait_valid(input int n);
		repeat (n) begin
			do begin
				@(posedge sys_clk);
				#1;
			end while (sample_valid[0] !== 1'b1);
		end
	endtask
	task automatic pulse_temp;
		@(posedge sys_clk);
		#1;
		tvalid = 4'h1;
		@(posedge sys_clk);
		#1;
		tvalid = 4'h0;
	endtask
	task automatic results;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		{sys_en, level, reg_wr} = 3'b110;
		{reg_addr, reg_wdata, tvalid, tcode, toffs} = '0;
		rst();
		foreach (regs[i]) begin
			wr(regs[i].a, regs[i].d);
			rd(regs[i].a, d);
			check("register", d, regs[i].e);
		end
		check("select pins", {28'h0, sel_n, sel_c, sel_b, sel_a}, 32'h0000000A);
		$display("register access test done");
		rst();
		for (int a = 0; a < 14; a++) begin
			rd(4'(a), d);
			check("reset value", d, (a == 13) ? 32'h0000000F : 32'h00000000);
		end
		check("select pins", {28'h0, sel_n, sel_c, sel_b, sel_a}, 32'h0000000F);
		$display("reset test done");
		foreach (dp[i]) begin
			level = dp[i].a[0];
			for (int c = 0; c < 3; c++) wr(4'(c), dp[i].d);
			wait_valid(5);
			check("sample a", {8'h00, samp_a}, dp[i].e);
			check("sample b", {8'h00, samp_b}, dp[i].e);
			check("sample c", {8'h00, samp_c}, dp[i].e);
			check("sample n", {8'h00, samp_n}, 32'h007FFFFF);
		end
		$display("gain test done");
		// Writes are ignored while the block is frozen
		@(posedge sys_clk);
		#1;
		sys_en = 1'b0;
		wr(4'h0, 32'h01230000);
		sys_en = 1'b1;
		rd(4'h0, d);
		check("frozen write", d, 32'h00000000);
		wr(4'h4, 32'h04000000);
		toffs[0] = 8'h01;
		tcode[0] = 24'h0FF800;
		wr(4'hD, 32'h0000000E);
		check("select a", {31'h0, sel_a}, 32'h00000000);
		repeat (10) @(posedge sys_clk);
		pulse_temp();
		rd(4'h9, d);
		check("early temperature", d, 32'h00000000);
		repeat (60) @(posedge sys_clk);
		pulse_temp();
		rd(4'h9, d);
		check("measured temperature", d, 32'h01000000);
		wait_valid(2);
		check("compensated a", {8'h00, samp_a}, 32'h00880000);
		check("uncompensated b", {8'h00, samp_b}, 32'h00800000);
		$display("temperature test done");
		results();
	end
endmodule // tb

bind ccg_top ccg_top_chk #(.TEMP_WAIT_CYCLES(TEMP_WAIT_CYCLES)) ccg_top_chk_inst (.sys_clk(sys_clk),
	.reset_n(reset_n), .sys_en(sys_en), .crystal_input(crystal_input), .sync_clk_out(sync_clk_out),
	.phase_a_channel_select(phase_a_channel_select), .phase_b_channel_select(phase_b_channel_select),
	.phase_c_channel_select(phase_c_channel_select), .neutral_channel_select(neutral_channel_select),
	.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.phase_a_current_sample(phase_a_current_sample), .sample_valid(sample_valid));
